// file: rtl/sep_defines.vh
// Offsets, field positions, opcodes and timing constants of the command port
`ifndef SEP_DEFINES_VH
`define SEP_DEFINES_VH

// Register offsets
`define SEP_OFS_CMD 9'h1B4
`define SEP_OFS_DATA 9'h1B8

// Command and data register fields
`define SEP_BUSY_BIT 31
`define SEP_OP_HI 30
`define SEP_OP_LO 28
`define SEP_OVF_BIT 18
`define SEP_TMO_BIT 17
`define SEP_CFG_BIT 16
`define SEP_ADDR_HI 15
`define SEP_ADDR_LO 0
`define SEP_DATA_HI 7

// Reset values
`define SEP_OP_RST 3'h0
`define SEP_ADDR_RST 16'h0000
`define SEP_DATA_RST 8'h00

// Operation codes
`define SEP_OP_READ 3'h0
`define SEP_OP_WDIS 3'h1
`define SEP_OP_WEN 3'h2
`define SEP_OP_WRITE 3'h3
`define SEP_OP_WALL 3'h4
`define SEP_OP_ERASE 3'h5
`define SEP_OP_EALL 3'h6
`define SEP_OP_RELOAD 3'h7

// Serial instruction opcodes and extended sub-codes
`define SEP_INS_READ 2'h2
`define SEP_INS_WRITE 2'h1
`define SEP_INS_ERASE 2'h3
`define SEP_INS_EXT 2'h0
`define SEP_EXT_WDIS 2'h0
`define SEP_EXT_WALL 2'h1
`define SEP_EXT_EALL 2'h2
`define SEP_EXT_WEN 2'h3

// Frame lengths in bits: start, opcode, address, optional data
`define SEP_LEN_CMD 6'h0B
`define SEP_LEN_DATA 6'h13

// Signature expected at the first location of a programmed part
`define SEP_SIGNATURE 8'hA5

// Program-cycle timeout
`define SEP_TIMEOUT_MS 30
`define SEP_CLK_KHZ 25000

`endif

// file: rtl/sep_serial_engine.v
// Bit-level serial engine: shifts a frame out, optionally a byte in, waits
`timescale 1ns/1ps
module sep_serial_engine #(
	parameter TIMEOUT_CYC = 750000,
	parameter TO_W = 20
) (
	input wire mclk_i,
	input wire srst_i,
	input wire start_i,
	input wire [31:0] frame_i,
	input wire [5:0] frame_len_i,
	input wire rx_en_i,
	input wire wait_ready_i,
	output wire done_o,
	output wire timed_out_o,
	output wire [7:0] rx_byte_o,
	output wire cs_o,
	output wire sck_o,
	output wire dout_o,
	input wire din_i
);
	localparam S_IDLE = 3'h0;
	localparam S_TX = 3'h1;
	localparam S_RX = 3'h2;
	localparam S_GAP = 3'h3;
	localparam S_WAIT = 3'h4;
	// Full-width count first, then cut to the timer width on purpose
	localparam [31:0] TO_LAST_W = TIMEOUT_CYC - 1;
	localparam [TO_W-1:0] TO_LAST = TO_LAST_W[TO_W-1:0];

	reg [2:0] state_r;
	reg phase_r;
	reg [5:0] cnt_r;
	reg [31:0] sh_r;
	reg [7:0] rx_r;
	reg [TO_W-1:0] to_r;
	reg done_r;
	reg tmo_r;
	reg cs_r;
	reg sck_r;
	reg do_r;

	assign done_o = done_r;
	assign timed_out_o = tmo_r;
	assign rx_byte_o = rx_r;
	assign cs_o = cs_r;
	assign sck_o = sck_r;
	assign dout_o = do_r;

	// Serial clock runs at half the system clock; data moves on the low phase
	always @(posedge mclk_i) begin
		if (srst_i) begin
			state_r <= S_IDLE;
			phase_r <= 1'b0;
			cnt_r <= 6'h00;
			sh_r <= 32'h00000000;
			rx_r <= 8'h00;
			to_r <= {TO_W{1'b0}};
			done_r <= 1'b0;
			tmo_r <= 1'b0;
			cs_r <= 1'b0;
			sck_r <= 1'b0;
			do_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			case (state_r)
			S_IDLE: begin
				if (start_i) begin
					sh_r <= frame_i;
					cnt_r <= frame_len_i;
					cs_r <= 1'b1;
					phase_r <= 1'b0;
					tmo_r <= 1'b0;
					state_r <= S_TX;
				end
			end
			S_TX: begin
				phase_r <= ~phase_r;
				if (!phase_r) begin
					sck_r <= 1'b0;
					do_r <= sh_r[31];
					sh_r <= {sh_r[30:0], 1'b0};
				end else begin
					sck_r <= 1'b1;
					cnt_r <= cnt_r - 6'h01;
					if (cnt_r == 6'h01) begin
						cnt_r <= 6'h08;
						state_r <= rx_en_i ? S_RX : S_GAP;
					end
				end
			end
			S_RX: begin
				phase_r <= ~phase_r;
				if (!phase_r) begin
					sck_r <= 1'b0;
					do_r <= 1'b0;
				end else begin
					// Sample on the rising serial edge, MSB first
					sck_r <= 1'b1;
					rx_r <= {rx_r[6:0], din_i};
					cnt_r <= cnt_r - 6'h01;
					if (cnt_r == 6'h01)
						state_r <= S_GAP;
				end
			end
			S_GAP: begin
				// Dropping select starts the internal program cycle
				sck_r <= 1'b0;
				cs_r <= 1'b0;
				do_r <= 1'b0;
				to_r <= {TO_W{1'b0}};
				if (wait_ready_i) begin
					state_r <= S_WAIT;
				end else begin
					done_r <= 1'b1;
					state_r <= S_IDLE;
				end
			end
			S_WAIT: begin
				// Absent part leaves data-in low, so only the timer ends this
				cs_r <= 1'b1;
				if (cs_r && din_i) begin
					cs_r <= 1'b0;
					done_r <= 1'b1;
					state_r <= S_IDLE;
				end else if (to_r == TO_LAST) begin
					cs_r <= 1'b0;
					tmo_r <= 1'b1;
					done_r <= 1'b1;
					state_r <= S_IDLE;
				end else begin
					to_r <= to_r + {{(TO_W-1){1'b0}}, 1'b1};
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule // sep_serial_engine

// file: rtl/sep_command_port.v
// Serial EEPROM command port: command/data registers, sequencer, loader
// Functional notes
// - Writing busy one starts selected operation
// - Busy holds during operation, self-clears, resets one
// - Read done means data register valid
// - Write without part: busy until timeout
// - Busy set at reset until loader finishes
// - Three-bit opcode at 30:28 selects operation
// - Opcode runs only with busy; one at a time
// - Write-disable sends erase/write lock instruction in three-wire mode
// - Write-enable unlocks erase/write in three-wire mode; software issues first
// - Write stores data byte at address
// - Write-all fills every location with data in three-wire mode
// - Reload checks signature, reports in loaded flag
// - Reload drops device ready until finished
// - No response in 30 ms sets timeout
// - Address field at 15:0, byte aligned
// - Data register bits 7:0 hold byte
`timescale 1ns/1ps
`include "sep_defines.vh"
module sep_command_port #(
	parameter TIMEOUT_CYC = `SEP_TIMEOUT_MS * `SEP_CLK_KHZ,
	parameter TO_W = 20
) (
	input wire mclk_i,
	input wire srst_i,
	input wire [8:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_rd_i,
	output wire [31:0] reg_rdata_o,
	input wire three_wire_mode_i,
	output wire ee_cs_o,
	output wire ee_sck_o,
	output wire ee_dout_o,
	input wire ee_din_i,
	output wire controller_busy_o,
	output wire cfg_loaded_o,
	output wire dev_ready_o
);
	localparam M_IDLE = 2'h0;
	localparam M_LAUNCH = 2'h1;
	localparam M_RUN = 2'h2;

	reg [1:0] state_r;
	reg busy_r;
	reg load_r;
	reg [2:0] op_r;
	reg [15:0] addr_r;
	reg [7:0] data_r;
	reg tmo_r;
	reg cfg_r;
	reg ready_r;
	reg [31:0] rdata_r;
	reg eng_start_r;
	reg [31:0] frame;
	reg [5:0] frame_len;
	reg rx_en;
	reg wait_rdy;
	reg supported;
	wire eng_done;
	wire eng_tmo;
	wire [7:0] eng_rx;
	wire [7:0] ee_addr;
	wire cmd_wr;
	wire data_wr;

	assign reg_rdata_o = rdata_r;
	assign controller_busy_o = busy_r;
	assign cfg_loaded_o = cfg_r;
	assign dev_ready_o = ready_r;
	// Loader always reads the first location
	assign ee_addr = load_r ? 8'h00 : addr_r[7:0];
	// Writes during an operation are dropped whole
	assign cmd_wr = reg_wr_i && reg_addr_i == `SEP_OFS_CMD && !busy_r;
	assign data_wr = reg_wr_i && reg_addr_i == `SEP_OFS_DATA && !busy_r;

	// Build the serial frame for the held opcode
	always @* begin
		frame = 32'h00000000;
		frame_len = `SEP_LEN_CMD;
		rx_en = 1'b0;
		wait_rdy = 1'b0;
		supported = three_wire_mode_i;
		if (load_r) begin
			frame = {1'b1, `SEP_INS_READ, ee_addr, 21'h000000};
			rx_en = 1'b1;
			supported = 1'b1;
		end else begin
			case (op_r)
			`SEP_OP_READ: begin
				frame = {1'b1, `SEP_INS_READ, ee_addr, 21'h000000};
				rx_en = 1'b1;
				supported = 1'b1;
			end
			`SEP_OP_WDIS: begin
				frame = {1'b1, `SEP_INS_EXT, `SEP_EXT_WDIS, 27'h0};
			end
			`SEP_OP_WEN: begin
				frame = {1'b1, `SEP_INS_EXT, `SEP_EXT_WEN, 27'h0};
			end
			`SEP_OP_WRITE: begin
				frame = {1'b1, `SEP_INS_WRITE, ee_addr, data_r, 13'h0};
				frame_len = `SEP_LEN_DATA;
				wait_rdy = 1'b1;
				supported = 1'b1;
			end
			`SEP_OP_WALL: begin
				frame = {1'b1, `SEP_INS_EXT, `SEP_EXT_WALL, 6'h00, data_r,
					13'h0};
				frame_len = `SEP_LEN_DATA;
				wait_rdy = 1'b1;
			end
			`SEP_OP_ERASE: begin
				frame = {1'b1, `SEP_INS_ERASE, ee_addr, 21'h000000};
				wait_rdy = 1'b1;
			end
			`SEP_OP_EALL: begin
				frame = {1'b1, `SEP_INS_EXT, `SEP_EXT_EALL, 27'h0};
				wait_rdy = 1'b1;
			end
			default: begin
				frame = 32'h00000000;
			end
			endcase
		end
	end

	// Sequencer, register writes and status flags
	always @(posedge mclk_i) begin
		if (srst_i) begin
			// Loader starts straight out of reset with busy raised
			state_r <= M_LAUNCH;
			busy_r <= 1'b1;
			load_r <= 1'b1;
			op_r <= `SEP_OP_RST;
			addr_r <= `SEP_ADDR_RST;
			data_r <= `SEP_DATA_RST;
			tmo_r <= 1'b0;
			cfg_r <= 1'b0;
			ready_r <= 1'b0;
			eng_start_r <= 1'b0;
		end else begin
			eng_start_r <= 1'b0;
			if (data_wr)
				data_r <= reg_wdata_i[`SEP_DATA_HI:0];
			if (cmd_wr) begin
				op_r <= reg_wdata_i[`SEP_OP_HI:`SEP_OP_LO];
				addr_r <= reg_wdata_i[`SEP_ADDR_HI:`SEP_ADDR_LO];
				// Flag clears come first so a same-cycle set wins below
				if (reg_wdata_i[`SEP_TMO_BIT])
					tmo_r <= 1'b0;
				if (reg_wdata_i[`SEP_CFG_BIT])
					cfg_r <= 1'b0;
				if (reg_wdata_i[`SEP_BUSY_BIT]) begin
					busy_r <= 1'b1;
					state_r <= M_LAUNCH;
					if (reg_wdata_i[`SEP_OP_HI:`SEP_OP_LO] == `SEP_OP_RELOAD) begin
						load_r <= 1'b1;
						cfg_r <= 1'b0;
						ready_r <= 1'b0;
					end
				end
			end
			case (state_r)
			M_IDLE: begin
			end
			M_LAUNCH: begin
				if (supported) begin
					eng_start_r <= 1'b1;
					state_r <= M_RUN;
				end else begin
					// Lock, unlock, single-erase and bulk codes need the three-wire part
					tmo_r <= 1'b1;
					busy_r <= 1'b0;
					state_r <= M_IDLE;
				end
			end
			M_RUN: begin
				if (eng_done) begin
					busy_r <= 1'b0;
					state_r <= M_IDLE;
					if (eng_tmo)
						tmo_r <= 1'b1;
					if (load_r) begin
						load_r <= 1'b0;
						ready_r <= 1'b1;
						cfg_r <= (eng_rx == `SEP_SIGNATURE);
					end else if (op_r == `SEP_OP_READ) begin
						data_r <= eng_rx;
					end
				end
			end
			default: state_r <= M_IDLE;
			endcase
		end
	end

	// Read data registered one cycle after the strobe; holes read zero
	always @(posedge mclk_i) begin
		if (srst_i) begin
			rdata_r <= 32'h00000000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
			`SEP_OFS_CMD: rdata_r <= {busy_r, op_r, 9'h000, 1'b0, tmo_r,
				cfg_r, addr_r};
			`SEP_OFS_DATA: rdata_r <= {24'h000000, data_r};
			default: rdata_r <= 32'h00000000;
			endcase
		end
	end

	// Bit engine holds the 30 ms program-cycle timer
	sep_serial_engine #(
		.TIMEOUT_CYC(TIMEOUT_CYC),
		.TO_W(TO_W)
	) u_engine (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.start_i(eng_start_r),
		.frame_i(frame),
		.frame_len_i(frame_len),
		.rx_en_i(rx_en),
		.wait_ready_i(wait_rdy),
		.done_o(eng_done),
		.timed_out_o(eng_tmo),
		.rx_byte_o(eng_rx),
		.cs_o(ee_cs_o),
		.sck_o(ee_sck_o),
		.dout_o(ee_dout_o),
		.din_i(ee_din_i)
	);
endmodule // sep_command_port

// file: bench/sep_ee_model.sv
// Behavioural serial EEPROM with a pull-down on its data output
`timescale 1ns/1ps
module sep_ee_model #(
	parameter DLY = 400
) (
	input wire cs_i,
	input wire sck_i,
	input wire di_i,
	input wire absent_i,
	output wire do_o
);
	logic [7:0] mem [0:255];
	logic [18:0] sh;
	logic [7:0] rd;
	logic wen, pend, rdm, q, f, g;
	int n;
	// A missing part leaves only the pull-down on the line
	assign do_o = q && !absent_i;
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		mem[0] = 8'hA5;
		{wen, pend, rdm, q, n} = 0;
	end
	// Bits are taken on the rising edge
	always @(posedge sck_i) if (cs_i) begin
		sh = {sh[17:0], di_i};
		n++;
		if (n == 11 && sh[10:8] == 3'h6) begin
			rd = mem[sh[7:0]];
			rdm = 1;
		end
	end
	// Read data moves on the falling edge, well ahead of the sample
	always @(negedge sck_i) if (cs_i && rdm) begin
		q = rd[7];
		rd = rd << 1;
	end
	// Frames act when the select drops; program ops need the unlock
	always @(negedge cs_i) begin
		q = 0;
		f = n == 11;
		g = n == 19;
		if (f && sh[9:6] == 4'h3) wen = 1;
		if (f && sh[9:6] == 4'h0) wen = 0;
		if (wen && f && sh[9:8] == 2'h3) mem[sh[7:0]] = 8'hFF;
		if (wen && f && sh[9:6] == 4'h2) foreach (mem[i]) mem[i] = 8'hFF;
		if (wen && g && sh[17:16] == 2'h1) mem[sh[15:8]] = sh[7:0];
		if (wen && g && sh[17:14] == 4'h1) foreach (mem[i]) mem[i] = sh[7:0];
		pend = wen && (g && sh[17:16] != 2'h2 || f && sh[9:8] == 2'h3);
		pend = pend || wen && f && sh[9:6] == 4'h2;
		{n, rdm} = 0;
	end
	// Ready answers a while after the select rises again
	always @(posedge cs_i) if (pend) begin
		#DLY q = cs_i;
		pend = 0;
	end
endmodule // sep_ee_model

// file: bench/sep_command_port_assertions.sv
// Pin-level checks of the command port
`timescale 1ns/1ps
module sep_command_port_assertions #(
	parameter TIMEOUT_CYC = 750000,
	parameter TO_W = 20
) (
	input wire mclk_i,
	input wire srst_i,
	input wire [8:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_rd_i,
	input wire [31:0] reg_rdata_o,
	input wire three_wire_mode_i,
	input wire ee_cs_o,
	input wire ee_sck_o,
	input wire ee_dout_o,
	input wire ee_din_i,
	input wire controller_busy_o,
	input wire cfg_loaded_o,
	input wire dev_ready_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	wire acc = reg_wr_i && reg_addr_i == 9'h1B4 && reg_wdata_i[31]
		&& !controller_busy_o;
	wire [2:0] op = reg_wdata_i[30:28];
	int run;
	// Busy stretch length; a stuck flag shows up here
	always @(posedge mclk_i) run <= controller_busy_o ? run + 1 : 0;
	AST_RST_BUSY: assert property ($fell(srst_i) |-> controller_busy_o
		&& !dev_ready_o && !cfg_loaded_o) else $error("busy not set by reset");
	AST_START: assert property (acc |=> controller_busy_o)
		else $error("command did not start");
	AST_SELF_CLR: assert property (run < TIMEOUT_CYC + 200)
		else $error("busy never cleared");
	AST_IDLE_LINK: assert property (!controller_busy_o |-> !ee_cs_o
		&& !ee_sck_o) else $error("link active while idle");
	AST_BUSY_CS: assert property (ee_cs_o |=> controller_busy_o)
		else $error("busy dropped during frame");
	AST_NOT_READY: assert property (!dev_ready_o |-> controller_busy_o)
		else $error("not ready while idle");
	AST_RELOAD: assert property (acc && op == 3'h7 |-> ##[1:3]
		!dev_ready_o && !cfg_loaded_o) else $error("reload kept ready");
	AST_RDATA_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data changed");
	AST_REFUSE: assert property (acc && !three_wire_mode_i
		&& op != 3'h0 && op != 3'h3 && op != 3'h7
		|=> !ee_cs_o [*3] ##0 !controller_busy_o) else $error("op not refused");
	cover property (acc && op == 3'h0);
	cover property (acc && op == 3'h7);
	cover property ($fell(controller_busy_o) && run > 60);
endmodule // sep_command_port_assertions

bind sep_command_port sep_command_port_assertions #(
	.TIMEOUT_CYC(TIMEOUT_CYC), .TO_W(TO_W)) chk (.mclk_i, .srst_i,
	.reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
	.three_wire_mode_i, .ee_cs_o, .ee_sck_o, .ee_dout_o, .ee_din_i,
	.controller_busy_o, .cfg_loaded_o, .dev_ready_o);

// file: bench/serial_eeprom_command_port_bench.sv
// Self-checking bench of the command port
`timescale 1ns/1ps
module serial_eeprom_command_port_bench;
	`define CHK(n, e, s) begin cmp_count++; \
		if ((s) !== (e)) begin failures++; \
		$display("mismatch %s exp %h got %h", n, e, s); end end
	logic mclk_i = 0, srst_i = 1, wr = 0, rd = 0, tw = 1, absent = 0;
	logic [8:0] ad = 0;
	logic [31:0] wd = 0, q;
	logic [31:0] r;
	wire [31:0] rdat;
	wire cs, sck, dout, din, busy, cfg, rdy;
	int failures = 0, cmp_count = 0, t;
	// Op, address, data, expected byte, {timeout, loaded}
	logic [31:0] rows [13] = '{32'h2_00_00_00_1, 32'h3_12_5A_00_1,
		32'h0_12_00_5A_1, 32'h5_12_00_00_1, 32'h0_12_00_FF_1,
		32'h4_00_3C_00_1, 32'h0_40_00_3C_1, 32'h6_00_00_00_1,
		32'h0_40_00_FF_1, 32'h1_00_00_00_1, 32'h3_12_77_00_3,
		32'h0_12_00_FF_1, 32'h7_00_00_00_0};
	sep_command_port #(.TIMEOUT_CYC(50)) uut (.mclk_i(mclk_i),
		.srst_i(srst_i), .reg_addr_i(ad), .reg_wr_i(wr), .reg_wdata_i(wd),
		.reg_rd_i(rd), .reg_rdata_o(rdat), .three_wire_mode_i(tw),
		.ee_cs_o(cs), .ee_sck_o(sck), .ee_dout_o(dout), .ee_din_i(din),
		.controller_busy_o(busy), .cfg_loaded_o(cfg), .dev_ready_o(rdy));
	sep_ee_model mem_m (.cs_i(cs), .sck_i(sck), .di_i(dout),
		.absent_i(absent), .do_o(din));
	initial forever #20 mclk_i = ~mclk_i;
	task complete_run;
		if (failures == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// One register cycle; read data is held, so take it a cycle late
	task automatic bus(input logic w, input logic [8:0] a,
		input logic [31:0] d);
		@(negedge mclk_i);
		ad = a;
		wd = d;
		wr = w;
		rd = !w;
		@(negedge mclk_i);
		{wr, rd} = 0;
		@(negedge mclk_i);
		q = rdat;
	endtask
	task automatic idle;
		t = 0;
		while (busy !== 1'b0 && t < 4000) begin
			@(negedge mclk_i);
			t++;
		end
		if (t == 4000) begin
			failures++;
			complete_run;
		end
	endtask
	initial begin
		repeat (4) @(negedge mclk_i);
		srst_i = 0;
		@(negedge mclk_i);
		`CHK("busy", 1'b1, busy)
		idle;
		`CHK("loaded", 2'h3, {cfg, rdy})
		bus(0, 9'h1B4, 0);
		`CHK("cmd", 32'h0001_0000, q)
		bus(0, 9'h1B8, 0);
		`CHK("data", 32'h0, q)
		// Every opcode in turn against the three-wire part
		foreach (rows[i]) begin
			r = rows[i];
			bus(1, 9'h1B8, {24'h0, r[19:12]});
			bus(1, 9'h1B4, {1'b1, r[30:28], 12'h0, 8'h0, r[27:20]});
			idle;
			bus(0, 9'h1B4, 0);
			`CHK("cmd", {1'b0, r[30:28], 10'h0, r[1:0], 8'h0, r[27:20]}, q)
			if (r[30:28] == 3'h0) begin
				bus(0, 9'h1B8, 0);
				`CHK("data", {24'h0, r[11:4]}, q)
			end
			if (r[1]) bus(1, 9'h1B4, 32'h0002_0000);
		end
		// Two-wire mode refuses the write-enable opcode
		tw = 0;
		bus(1, 9'h1B4, 32'hA000_0000);
		idle;
		bus(0, 9'h1B4, 0);
		`CHK("cmd", 32'h2002_0000, q)
		bus(1, 9'h1B4, 32'h0002_0000);
		tw = 1;
		// Write with no part fitted, poked while busy
		absent = 1;
		bus(1, 9'h1B8, 32'h66);
		bus(1, 9'h1B4, 32'hB000_0034);
		bus(1, 9'h1B4, 32'h8000_0055);
		bus(1, 9'h1B8, 32'h99);
		idle;
		`CHK("wait", 1'b1, t > 60)
		bus(0, 9'h1B4, 0);
		`CHK("cmd", 32'h3002_0034, q)
		bus(0, 9'h1B8, 0);
		`CHK("data", 32'h66, q)
		absent = 0;
		// Reset in mid-operation restarts the loader
		bus(1, 9'h1B4, 32'h8002_0012);
		srst_i = 1;
		repeat (2) @(negedge mclk_i);
		`CHK("rst", 2'h2, {busy, rdy})
		srst_i = 0;
		idle;
		`CHK("reload", 2'h1, {cfg, rdy})
		complete_run;
	end
endmodule // serial_eeprom_command_port_bench
